// file: pkg/tcoe_pkg.sv
// Contract
// - Group output-enable bit at 0 forces every transmit channel of that group high-impedance; the code still drives them while control bit 12 is 1.
// - With group enabled, a channel whose mode field is 1-1-1 is high-impedance; the code still drives it while control bit 12 is 1.
// - Drive-enable pin low and standby bit 0 put all transmit drivers high-impedance; the code still drives every transmit pin while control bit 12 is 1.
// - Drive-enable pin or standby bit 1 lets drivers run, subject to group and channel gating.
// - Control bit 15 at 1 resets the device like the reset pin; software clears it.
// - Control bit 14 at 1 routes each receive stream straight to its transmit stream.
// - Control bit 13 sets indication polarity: 1 means high is active, 0 inverts.
// - Indication operation is chosen per group by the rate select registers.
// - Control bit 12 at 1 turns every transmit pin into an indication output.
// - Control bit 11 high holds the pseudo-random transmitter at its initial state.
// - A rising edge of control bit 10 clears the error count register.
// - A rising edge of control bit 9 starts the bit error test.
// - Control bit 8 at 1 fills the whole map, ignoring start and end addresses.
// - Fill pattern in bits 7-5 goes into mode bits of each targeted high word.
// - Rising edge of bit 4 begins a fill; device clears the bit when finished.
// - Software writing 0 to the fill-begin bit while it is 1 aborts the fill.
// - Control bit 3 at 1 zeroes low word bits 14-0 during a fill.
// - Bits 1-0 select processor memory: low, high, data memory, or reserved.
// - During soft reset reads work, only the soft reset bit is writable, held 20ns.
`default_nettype none
package tcoe_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int STREAMS = 64;
  localparam int GROUPS = 8;
  localparam int GROUP_STREAMS = 8;

  // ----------------------------------------
  // Control word layout and decode
  // ----------------------------------------
  typedef struct packed {
    logic softReset;
    logic passthrough;
    logic polarity;
    logic allPinsInd;
    logic prbsInit;
    logic errClear;
    logic errStart;
    logic wholeFill;
    logic [2:0] fillPattern;
    logic fillBegin;
    logic clearLow;
    logic standby;
    logic [1:0] memSelect;
  } tcoe_ctrl_t;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_ADDR = 16'h0000;
  localparam logic [15:0] CTRL_ADDR_MASK = 16'hFE00;
  localparam logic [15:0] SOFT_RESET_MASK = 16'h8000;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [2:0] MODE_HIZ = 3'h7;
  localparam logic [1:0] MSEL_CM_LOW = 2'h0;
  localparam logic [1:0] MSEL_CM_HIGH = 2'h1;
  localparam logic [1:0] MSEL_DATA = 2'h2;
  localparam logic [1:0] MSEL_RESERVED = 2'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int SOFT_RESET_MIN_NS = 20;
  localparam int SOFT_RESET_MIN_CYC_RAW = (SOFT_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] SOFT_RESET_MIN_CYC = (SOFT_RESET_MIN_CYC_RAW < 1) ? 4'h1 : 4'(SOFT_RESET_MIN_CYC_RAW);

endpackage
`default_nettype wire

// file: rtl/tcoe_group_gate.sv
`timescale 1ns/10ps
`default_nettype none
module tcoe_group_gate (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic groupEnable,
  input wire logic groupIndMode,
  input wire logic drivePin,
  input wire logic standby,
  input wire logic polarity,
  input wire logic allPinsInd,
  input wire logic passthrough,
  input wire logic [3*tcoe_pkg::GROUP_STREAMS-1:0] chanMode,
  // Stream data
  input wire logic [tcoe_pkg::GROUP_STREAMS-1:0] rxData,
  input wire logic [tcoe_pkg::GROUP_STREAMS-1:0] swData,
  // Pins
  output logic [tcoe_pkg::GROUP_STREAMS-1:0] txData,
  output logic [tcoe_pkg::GROUP_STREAMS-1:0] txOeN,
  output logic [tcoe_pkg::GROUP_STREAMS-1:0] indPin,
  output logic [tcoe_pkg::GROUP_STREAMS-1:0] indOeN
);
  import tcoe_pkg::*;

  logic [GROUP_STREAMS-1:0] txData_d, txOeN_d, indPin_d, indOeN_d;
  logic [GROUP_STREAMS-1:0] txData_q, txOeN_q, indPin_q, indOeN_q;
  logic active;
  logic drvOn;

  // ----------------------------------------
  // Per-stream gating
  // ----------------------------------------
  always_comb begin
    drvOn = drivePin | standby;
    for (int i = 0; i < GROUP_STREAMS; i++) begin
      active = groupEnable & (chanMode[3*i +: 3] != MODE_HIZ) & drvOn;
      indPin_d[i] = polarity ? active : ~active;
      indOeN_d[i] = ~(groupIndMode | allPinsInd);
      if (allPinsInd) begin
        txData_d[i] = indPin_d[i];
        txOeN_d[i] = 1'b0;
      end else begin
        txData_d[i] = passthrough ? rxData[i] : swData[i];
        txOeN_d[i] = ~active;
      end
    end
  end

  // Output registers, high-impedance under reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      txData_q <= '0;
      txOeN_q <= '1;
      indPin_q <= '0;
      indOeN_q <= '1;
    end else begin
      txData_q <= txData_d;
      txOeN_q <= txOeN_d;
      indPin_q <= indPin_d;
      indOeN_q <= indOeN_d;
    end
  end

  assign txData = txData_q;
  assign txOeN = txOeN_q;
  assign indPin = indPin_q;
  assign indOeN = indOeN_q;

endmodule
`default_nettype wire

// file: rtl/tcoe_top.sv
`timescale 1ns/10ps
`default_nettype none
module tcoe_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Processor port
  input wire logic [15:0] procAddr,
  input wire logic procWrEn,
  input wire logic procRdEn,
  input wire logic [15:0] procWrData,
  output logic [15:0] procRdData,
  output logic procRdValid,
  // Output gating inputs
  input wire logic outputDriveEnablePin,
  input wire logic [tcoe_pkg::GROUPS-1:0] groupOutputEnable,
  input wire logic [tcoe_pkg::GROUPS-1:0] groupIndicationMode,
  input wire logic [3*tcoe_pkg::STREAMS-1:0] channelMode,
  // Stream data
  input wire logic [tcoe_pkg::STREAMS-1:0] rxData,
  input wire logic [tcoe_pkg::STREAMS-1:0] switchedData,
  // Transmit and indication pins
  output logic [tcoe_pkg::STREAMS-1:0] txData,
  output logic [tcoe_pkg::STREAMS-1:0] txOeN,
  output logic [tcoe_pkg::STREAMS-1:0] indPin,
  output logic [tcoe_pkg::STREAMS-1:0] indOeN,
  // Fill engine
  input wire logic fillDone,
  output logic fillStart,
  output logic fillAbort,
  output logic wholeMapFill,
  output logic [2:0] fillPattern,
  output logic clearLowWordOnFill,
  // Error test and other controls
  output logic errorCountClear,
  output logic errorTestStart,
  output logic prbsGeneratorInit,
  output logic [1:0] memorySelect,
  output logic deviceReset
);
  import tcoe_pkg::*;

  tcoe_ctrl_t ctrl_d, ctrl_q;
  logic fillStart_d, fillStart_q, fillAbort_d, fillAbort_q;
  logic errClr_d, errClr_q, errStart_d, errStart_q;
  logic [3:0] hold_d, hold_q;
  logic [15:0] rdData_d, rdData_q;
  logic rdValid_d, rdValid_q;
  logic ctrlSel, ctrlWr;
  tcoe_ctrl_t wrWord;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    if ((procAddr & CTRL_ADDR_MASK) == CTRL_ADDR) begin
      ctrlSel = 1'b1;
    end else begin
      ctrlSel = 1'b0;
    end
    ctrlWr = procWrEn & ctrlSel;
    wrWord = tcoe_ctrl_t'(procWrData);
  end

  // ----------------------------------------
  // Control word update
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    fillStart_d = 1'b0;
    fillAbort_d = 1'b0;
    errClr_d = 1'b0;
    errStart_d = 1'b0;
    if (ctrlWr && ctrl_q.softReset) begin
      ctrl_d = tcoe_ctrl_t'(CTRL_RESET);
      ctrl_d.softReset = wrWord.softReset;
    end else if (ctrlWr) begin
      ctrl_d = wrWord;
      fillStart_d = wrWord.fillBegin & ~ctrl_q.fillBegin;
      fillAbort_d = ~wrWord.fillBegin & ctrl_q.fillBegin;
      errClr_d = wrWord.errClear & ~ctrl_q.errClear;
      errStart_d = wrWord.errStart & ~ctrl_q.errStart;
    end else if (fillDone && ctrl_q.fillBegin) begin
      ctrl_d.fillBegin = 1'b0;
      ctrl_d.fillPattern = 3'h0;
    end
  end

  // Control word registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= tcoe_ctrl_t'(CTRL_RESET);
      fillStart_q <= 1'b0;
      fillAbort_q <= 1'b0;
      errClr_q <= 1'b0;
      errStart_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      fillStart_q <= fillStart_d;
      fillAbort_q <= fillAbort_d;
      errClr_q <= errClr_d;
      errStart_q <= errStart_d;
    end
  end

  // ----------------------------------------
  // Soft reset stretch and readback
  // ----------------------------------------
  always_comb begin
    hold_d = hold_q;
    if (ctrl_q.softReset) begin
      hold_d = SOFT_RESET_MIN_CYC;
    end else if (hold_q != 4'h0) begin
      hold_d = hold_q - 4'h1;
    end
    rdValid_d = procRdEn;
    rdData_d = 16'h0000;
    if (procRdEn && ctrlSel) begin
      rdData_d = 16'(ctrl_q);
    end
  end

  // Stretch counter and read data registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_q <= 4'h0;
      rdData_q <= 16'h0000;
      rdValid_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  assign deviceReset = rst | ctrl_q.softReset | (hold_q != 4'h0);
  assign procRdData = rdData_q;
  assign procRdValid = rdValid_q;

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign fillStart = fillStart_q;
  assign fillAbort = fillAbort_q;
  assign wholeMapFill = ctrl_q.wholeFill;
  assign fillPattern = ctrl_q.fillPattern;
  assign clearLowWordOnFill = ctrl_q.clearLow;
  assign errorCountClear = errClr_q;
  assign errorTestStart = errStart_q;
  assign prbsGeneratorInit = ctrl_q.prbsInit;
  assign memorySelect = ctrl_q.memSelect;

  // ----------------------------------------
  // Per-group output gating
  // ----------------------------------------
  for (genvar g = 0; g < GROUPS; g++) begin : gGroup
    tcoe_group_gate uGate (
      .mclk(mclk),
      .rst(deviceReset),
      .groupEnable(groupOutputEnable[g]),
      .groupIndMode(groupIndicationMode[g]),
      .drivePin(outputDriveEnablePin),
      .standby(ctrl_q.standby),
      .polarity(ctrl_q.polarity),
      .allPinsInd(ctrl_q.allPinsInd),
      .passthrough(ctrl_q.passthrough),
      .chanMode(channelMode[3*GROUP_STREAMS*g +: 3*GROUP_STREAMS]),
      .rxData(rxData[GROUP_STREAMS*g +: GROUP_STREAMS]),
      .swData(switchedData[GROUP_STREAMS*g +: GROUP_STREAMS]),
      .txData(txData[GROUP_STREAMS*g +: GROUP_STREAMS]),
      .txOeN(txOeN[GROUP_STREAMS*g +: GROUP_STREAMS]),
      .indPin(indPin[GROUP_STREAMS*g +: GROUP_STREAMS]),
      .indOeN(indOeN[GROUP_STREAMS*g +: GROUP_STREAMS])
    );
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_group_off;
    !deviceReset && !groupOutputEnable[0] && !ctrl_q.allPinsInd |=> (txOeN[7:0] == 8'hFF);
  endproperty
  a_group_off: assert property (p_group_off) else $error("group disabled but driver on");

  property p_chan_hiz;
    !deviceReset && groupOutputEnable[0] && channelMode[2:0] == MODE_HIZ && !ctrl_q.allPinsInd |=> txOeN[0];
  endproperty
  a_chan_hiz: assert property (p_chan_hiz) else $error("high-impedance channel driven");

  property p_all_off;
    !outputDriveEnablePin && !ctrl_q.standby && !ctrl_q.allPinsInd |=> (txOeN == '1);
  endproperty
  a_all_off: assert property (p_all_off) else $error("drivers on with pin and standby low");

  property p_drive_on;
    !deviceReset && groupOutputEnable[0] && channelMode[2:0] != MODE_HIZ
      && (outputDriveEnablePin || ctrl_q.standby) |=> !txOeN[0];
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("enabled channel not driven");

  property p_soft_reset;
    ctrlWr && wrWord.softReset |=> deviceReset ##1 deviceReset;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not take effect");

  property p_passthrough;
    !deviceReset && ctrl_q.passthrough && !ctrl_q.allPinsInd |=> txData[5] == $past(rxData[5]);
  endproperty
  a_passthrough: assert property (p_passthrough) else $error("passthrough data mismatch");

  property p_polarity;
    !deviceReset && $past(!deviceReset) && !ctrl_q.allPinsInd && $stable(ctrl_q.allPinsInd) && $stable(ctrl_q.polarity)
      |-> indPin[0] == (ctrl_q.polarity ~^ !txOeN[0]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("indication disagrees with driver");

  property p_err_clear;
    ctrlWr && !ctrl_q.softReset && wrWord.errClear && !ctrl_q.errClear |=> errorCountClear ##1 !errorCountClear;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("clear pulse wrong");

  property p_fill_done;
    fillDone && !ctrlWr && ctrl_q.fillBegin |=> !ctrl_q.fillBegin && fillPattern == 3'h0;
  endproperty
  a_fill_done: assert property (p_fill_done) else $error("fill begin not self-cleared");

  property p_fill_abort;
    ctrlWr && !ctrl_q.softReset && ctrl_q.fillBegin && !wrWord.fillBegin |=> fillAbort ##1 !fillAbort;
  endproperty
  a_fill_abort: assert property (p_fill_abort) else $error("abort pulse missing");

  property p_srs_lock;
    ctrlWr && ctrl_q.softReset |=> ctrl_q.passthrough == 1'b0 && memorySelect == MSEL_CM_LOW;
  endproperty
  a_srs_lock: assert property (p_srs_lock) else $error("write accepted during soft reset");

  // ----------------------------------------
  // Control word field checks
  // ----------------------------------------
  property p_err_start;
    ctrlWr && !ctrl_q.softReset && wrWord.errStart && !ctrl_q.errStart |=> errorTestStart ##1 !errorTestStart;
  endproperty
  a_err_start: assert property (p_err_start) else $error("start pulse wrong");

  property p_err_quiet;
    !(ctrlWr && !ctrl_q.softReset && wrWord.errClear && !ctrl_q.errClear) |=> !errorCountClear;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("clear pulse without rising write");

  property p_fill_start;
    ctrlWr && !ctrl_q.softReset && wrWord.fillBegin && !ctrl_q.fillBegin |=> fillStart && ctrl_q.fillBegin;
  endproperty
  a_fill_start: assert property (p_fill_start) else $error("fill start pulse missing");

  property p_prbs_init;
    ctrlWr && !ctrl_q.softReset |=> prbsGeneratorInit == $past(wrWord.prbsInit);
  endproperty
  a_prbs_init: assert property (p_prbs_init) else $error("sequence init level wrong");

  property p_whole_fill;
    ctrlWr && !ctrl_q.softReset |=> wholeMapFill == $past(wrWord.wholeFill);
  endproperty
  a_whole_fill: assert property (p_whole_fill) else $error("whole map fill level wrong");

  property p_fill_pattern;
    ctrlWr && !ctrl_q.softReset |=> fillPattern == $past(wrWord.fillPattern);
  endproperty
  a_fill_pattern: assert property (p_fill_pattern) else $error("fill pattern wrong");

  property p_clear_low;
    ctrlWr && !ctrl_q.softReset |=> clearLowWordOnFill == $past(wrWord.clearLow);
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("low word clear level wrong");

  property p_mem_select;
    ctrlWr && !ctrl_q.softReset |=> memorySelect == $past(wrWord.memSelect);
  endproperty
  a_mem_select: assert property (p_mem_select) else $error("memory select wrong");

  property p_readback;
    procRdEn && ctrlSel |=> procRdValid && procRdData == 16'($past(ctrl_q));
  endproperty
  a_readback: assert property (p_readback) else $error("control word readback wrong");

  // ----------------------------------------
  // Pin use checks
  // ----------------------------------------
  property p_all_ind;
    !deviceReset && ctrl_q.allPinsInd |=> txOeN == '0 && txData == indPin;
  endproperty
  a_all_ind: assert property (p_all_ind) else $error("transmit pin not acting as indication");

  property p_ind_enable;
    !deviceReset |=> indOeN[7:0] == {8{!$past(groupIndicationMode[0]) && !$past(ctrl_q.allPinsInd)}};
  endproperty
  a_ind_enable: assert property (p_ind_enable) else $error("indication enable wrong for group");

  property p_switched;
    !deviceReset && !ctrl_q.passthrough && !ctrl_q.allPinsInd |=> txData[61] == $past(switchedData[61]);
  endproperty
  a_switched: assert property (p_switched) else $error("switched data mismatch");

  c_fill_run: cover property (fillStart ##[1:20] fillDone);
  c_passthrough: cover property (ctrl_q.passthrough && !txOeN[0]);
  c_soft_reset: cover property (ctrl_q.softReset ##1 !ctrl_q.softReset);
  c_fill_abort: cover property (fillAbort);
  c_all_ind: cover property (ctrl_q.allPinsInd && !txOeN[0]);

endmodule
`default_nettype wire

// file: testbench/tcoe_fill_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcoe_fill_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fill requests from the device
  input wire logic fillStart,
  input wire logic fillAbort,
  input wire logic [7:0] doneDelay,
  // Completion back to the device
  output logic fillDone
);
  logic busy_q;
  logic busy_d;
  logic [7:0] count_q;
  logic [7:0] count_d;

  // Next state of the fill engine
  always_comb begin
    busy_d = busy_q;
    count_d = count_q;
    if (fillAbort) begin
      busy_d = 1'b0;
    end else if (fillStart) begin
      busy_d = 1'b1;
      count_d = doneDelay;
    end else if (busy_q && count_q != 8'h00) begin
      count_d = count_q - 8'h01;
    end else begin
      busy_d = 1'b0;
    end
  end

  // Registers of the fill engine
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_q <= 1'b0;
      count_q <= 8'h00;
    end else begin
      busy_q <= busy_d;
      count_q <= count_d;
    end
  end

  // One-cycle completion pulse
  assign fillDone = busy_q && count_q == 8'h00;
endmodule
`default_nettype wire

// file: testbench/tb_tcoe_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_tcoe_top;
  import tcoe_pkg::*;
  `define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
  logic mclk, rst, procWrEn, procRdEn, procRdValid, outputDriveEnablePin;
  logic [15:0] procAddr, procWrData, procRdData;
  logic [GROUPS-1:0] groupOutputEnable, groupIndicationMode;
  logic [3*STREAMS-1:0] channelMode;
  logic [STREAMS-1:0] rxData, switchedData, txData, txOeN, indPin, indOeN;
  logic fillDone, fillStart, fillAbort, wholeMapFill, clearLowWordOnFill;
  logic errorCountClear, errorTestStart, prbsGeneratorInit, deviceReset;
  logic [2:0] fillPattern;
  logic [1:0] memorySelect;
  logic [7:0] doneDelay;
  logic [15:0] a, d;
  tcoe_ctrl_t c;
  int failures, comparisons, n;

  tcoe_top dut (.mclk, .rst, .procAddr, .procWrEn, .procRdEn, .procWrData, .procRdData, .procRdValid,
    .outputDriveEnablePin, .groupOutputEnable, .groupIndicationMode, .channelMode, .rxData, .switchedData,
    .txData, .txOeN, .indPin, .indOeN, .fillDone, .fillStart, .fillAbort, .wholeMapFill, .fillPattern,
    .clearLowWordOnFill, .errorCountClear, .errorTestStart, .prbsGeneratorInit, .memorySelect, .deviceReset);
  tcoe_fill_model fillModel (.mclk, .rst(deviceReset), .fillStart, .fillAbort, .doneDelay, .fillDone);

  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic wr(input logic [15:0] wa, input logic [15:0] wd);
    @(negedge mclk);
    procAddr = wa;
    procWrData = wd;
    procWrEn = 1'b1;
    @(negedge mclk);
    procWrEn = 1'b0;
  endtask

  task automatic rd(input logic [15:0] ra, input logic [15:0] ex, input string nm);
    @(negedge mclk);
    procAddr = ra;
    procRdEn = 1'b1;
    @(negedge mclk);
    procRdEn = 1'b0;
    `CHK("readValid", 1'b1, procRdValid)
    `CHK(nm, ex, procRdData)
  endtask

  task automatic check_gate(input tcoe_ctrl_t gc);
    logic [STREAMS-1:0] eTx, eOe, eInd, eIndOe;
    logic act;
    int g;
    for (int s = 0; s < STREAMS; s++) begin
      g = s / GROUP_STREAMS;
      act = groupOutputEnable[g] & (channelMode[3*s +: 3] != MODE_HIZ) & (outputDriveEnablePin | gc.standby);
      eInd[s] = gc.polarity ? act : ~act;
      eTx[s] = gc.allPinsInd ? eInd[s] : (gc.passthrough ? rxData[s] : switchedData[s]);
      eOe[s] = gc.allPinsInd ? 1'b0 : ~act;
      eIndOe[s] = ~(groupIndicationMode[g] | gc.allPinsInd);
    end
    `CHK("txOeN", eOe, txOeN)
    `CHK("txData", eTx, txData)
    `CHK("indPin", eInd, indPin)
    `CHK("indOeN", eIndOe, indOeN)
  endtask

  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (6000) @(posedge mclk);
    failures++;
    $display("watchdog expired");
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, procWrEn, procRdEn, procAddr, procWrData, outputDriveEnablePin} = {2'b10, 34'h0};
    {groupOutputEnable, groupIndicationMode, channelMode, rxData, switchedData} = '0;
    doneDelay = 8'h05;
    failures = 0;
    comparisons = 0;
    void'($urandom(32'h0CF5));
    repeat (20) @(negedge mclk);
    `CHK("resetHeld", 1'b1, deviceReset)
    rst = 1'b0;
    rd(CTRL_ADDR, CTRL_RESET, "ctrlReset");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = (16'($urandom) & 16'h7FEC) | 16'(i % 4);
      a = 16'($urandom) & ~CTRL_ADDR_MASK;
      wr(a, d);
      `CHK("memSelect", d[1:0], memorySelect)
      `CHK("prbsInit", d[11], prbsGeneratorInit)
      `CHK("wholeFill", d[8], wholeMapFill)
      `CHK("clearLow", d[3], clearLowWordOnFill)
      rd(a, d, "ctrlBack");
    end
    wr(16'h0200, 16'hFFFF);
    rd(16'h0200, 16'h0000, "unmapped");
    rd(CTRL_ADDR, d, "ctrlKept");
    $display("test readback done");
    for (int b = 9; b <= 10; b++) begin
      wr(CTRL_ADDR, 16'h0000);
      wr(CTRL_ADDR, 16'h0001 << b);
      `CHK("pulseRise", 1'b1, (b == 10) ? errorCountClear : errorTestStart)
      @(negedge mclk);
      `CHK("pulseOnce", 1'b0, (b == 10) ? errorCountClear : errorTestStart)
      wr(CTRL_ADDR, 16'h0001 << b);
      `CHK("pulseHigh", 1'b0, (b == 10) ? errorCountClear : errorTestStart)
    end
    $display("test pulses done");
    wr(CTRL_ADDR, 16'h0000);
    wr(CTRL_ADDR, 16'h01F8);
    `CHK("fillStart", 1'b1, fillStart)
    `CHK("fillPattern", 3'h7, fillPattern)
    n = 0;
    while (fillDone !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    `CHK("fillDone", 1'b1, fillDone)
    @(negedge mclk);
    rd(CTRL_ADDR, 16'h0108, "fillCleared");
    doneDelay = 8'h60;
    wr(CTRL_ADDR, 16'h0010);
    repeat (3) @(negedge mclk);
    wr(CTRL_ADDR, 16'h0000);
    `CHK("fillAbort", 1'b1, fillAbort)
    $display("test fill done");
    wr(CTRL_ADDR, SOFT_RESET_MASK);
    `CHK("softReset", 1'b1, deviceReset)
    wr(CTRL_ADDR, 16'h8410);
    `CHK("noPulse", 1'b0, errorCountClear)
    rd(CTRL_ADDR, SOFT_RESET_MASK, "softOnly");
    wr(CTRL_ADDR, 16'h0000);
    `CHK("softStretch", 1'b1, deviceReset)
    repeat (2) @(negedge mclk);
    `CHK("softDone", 1'b0, deviceReset)
    $display("test soft reset done");
    for (int i = 0; i < 24; i++) begin
      c = '0;
      {c.passthrough, c.polarity, c.allPinsInd, c.standby} = 4'($urandom);
      wr(CTRL_ADDR, c);
      groupOutputEnable = (i == 0) ? 8'h00 : 8'($urandom);
      groupIndicationMode = 8'($urandom);
      outputDriveEnablePin = 1'($urandom);
      channelMode = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      rxData = {$urandom, $urandom};
      switchedData = {$urandom, $urandom};
      @(negedge mclk);
      check_gate(c);
    end
    $display("test gating done");
    stop_test();
  end
endmodule
`default_nettype wire
